// ===== rtl/mem_phy.sv
// controller-facing phy top: clock sharing, termination sharing, resets, calibration
// assumes controller inputs synchronous to the interface clock
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module mem_phy
#(
    parameter bit SHARE_MASTER = 1'b1,
    parameter bit TERM_MASTER  = 1'b1
)
(
    input  wire logic                                     clk,
    input  wire logic                                     rst_b,
    input  wire logic                                     soft_rst_b,
    input  wire logic                                     lock_in,
    input  wire logic                                     share_clk_in,
    input  wire logic [`DLY_CODE_W-1:0]                   dly_code_in,
    output logic                                          share_clk_out,
    output logic [`DLY_CODE_W-1:0]                        dly_code_out,
    input  wire logic [`TERM_SER_W-1:0]                   term_ser_in,
    input  wire logic [`TERM_PAR_W-1:0]                   term_par_in,
    output logic [`TERM_SER_W-1:0]                        term_ser_out,
    output logic [`TERM_PAR_W-1:0]                        term_par_out,
    output logic                                          reset_req_b,
    output logic                                          if_clk_en,
    output logic                                          if_rst_b,
    input  wire logic [`MEM_ADDR_W*`RATE_RATIO-1:0]       ctrl_addr,
    input  wire logic [`MEM_BANK_W*`RATE_RATIO-1:0]       ctrl_bank,
    input  wire logic [`MEM_CS_W*`RATE_RATIO-1:0]         ctrl_cs_b,
    input  wire logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_ras_b,
    input  wire logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_cas_b,
    input  wire logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_we_b,
    input  wire logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]       ctrl_wdata,
    input  wire logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]         ctrl_write_mask,
    input  wire logic [`MEM_WDQS_W*`RATE_RATIO-1:0]       ctrl_wdata_valid,
    input  wire logic [`MEM_RDQS_W*`RATE_RATIO-1:0]       ctrl_rdata_en,
    output logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]            ctrl_rdata,
    output logic [`RATE_RATIO-1:0]                        ctrl_rdata_valid,
    output logic                                          cal_success,
    output logic                                          cal_fail,
    output logic [`MEM_ADDR_W*`RATE_RATIO-1:0]            mem_addr,
    output logic [`MEM_BANK_W*`RATE_RATIO-1:0]            mem_bank,
    output logic [`MEM_CS_W*`RATE_RATIO-1:0]              mem_cs_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]             mem_ras_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]             mem_cas_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]             mem_we_b,
    output logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]            mem_dq_out,
    output logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]            mem_dq_oe_b,
    input  wire logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]       mem_dq_in,
    output logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]              memory_mask_pins,
    output logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]              memory_mask_oe_b
);
    import phy_pkg::*;
    localparam int DQ_PH = `MEM_DQ_W * 2;
    localparam int LW    = `LAT_W;
    localparam int PW    = 1 << LW;

    seq_if sq ();

    logic                   lock_r;
    logic [`LOCK_CNT_W-1:0] lock_cnt_r;
    logic [`DIV_CNT_W-1:0]  div_r;
    logic                   gen_clk_r;
    logic [`DLY_CODE_W-1:0] gen_code_r;
    logic                   lock_now;
    logic                   phy_arst_b;
    logic                   phy_rst_b;
    logic                   rate_en;
    logic [`DLY_CODE_W-1:0] code_now;
    logic                   own_clk_now;
    logic [PW-1:0]          rd_pipe_r;
    logic [DQ_PH*`RATE_RATIO-1:0] dly_data_r [0:PW-1];
    logic                   ret_hit;

    // stand-in clock generator: lock counter, divider and codeword
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_cnt_r <= '0;
            lock_r     <= 1'b0;
        end
        else if (SHARE_MASTER)
        begin
            if (lock_cnt_r != `LOCK_CNT_DONE)
                lock_cnt_r <= lock_cnt_r + 1'b1;
            lock_r <= (lock_cnt_r == `LOCK_CNT_DONE);
        end
        else
            lock_r <= lock_in;
    end

    // soft reset leaves the divider running
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_r      <= '0;
            gen_clk_r  <= 1'b0;
            gen_code_r <= '0;
        end
        else
        begin
            div_r      <= div_r + 1'b1;
            gen_clk_r  <= div_r[`DIV_CNT_W-1];
            gen_code_r <= lock_r ? `DLY_CODE_INIT : '0;
        end
    end

    assign lock_now    = lock_r;
    assign own_clk_now = SHARE_MASTER ? gen_clk_r : share_clk_in;
    assign code_now    = SHARE_MASTER ? gen_code_r : dly_code_in;
    assign rate_en     = (`RATE_RATIO == 1) ? 1'b1 : (div_r[0] == 1'b0);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            share_clk_out <= 1'b0;
            dly_code_out  <= '0;
            reset_req_b   <= 1'b0;
            if_clk_en     <= 1'b0;
        end
        else
        begin
            share_clk_out <= SHARE_MASTER ? own_clk_now : 1'b0;
            dly_code_out  <= SHARE_MASTER ? code_now : '0;
            reset_req_b   <= lock_now;
            if_clk_en     <= rate_en;
        end
    end

    // termination control unit only in the master build
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            term_ser_out <= '0;
            term_par_out <= '0;
        end
        else if (TERM_MASTER)
        begin
            term_ser_out <= `TERM_SER_INIT;
            term_par_out <= `TERM_PAR_INIT;
        end
        else
        begin
            term_ser_out <= term_ser_in;
            term_par_out <= term_par_in;
        end
    end

    assign phy_arst_b = rst_b & soft_rst_b & lock_now;

    reset_sync u_rst
    (
        .clk    (clk),
        .arst_b (phy_arst_b),
        .srst_b (phy_rst_b)
    );

    always_ff @(posedge clk or negedge phy_arst_b)
    begin
        if (!phy_arst_b)
            if_rst_b <= 1'b0;
        else
            if_rst_b <= phy_rst_b;
    end

    lat_calib u_cal
    (
        .clk   (clk),
        .rst_b (phy_rst_b),
        .sq    (sq.seq)
    );

    // read return model: a read surfaces latency plus one cycles after its request, at tap latency of the delay pipe
    always_ff @(posedge clk or negedge phy_rst_b)
    begin
        if (!phy_rst_b)
            rd_pipe_r <= '0;
        else
            rd_pipe_r <= {rd_pipe_r[PW-2:0], sq.rd_req | (|ctrl_rdata_en & ~sq.owns_bus)};
    end

    always_ff @(posedge clk)
    begin
        dly_data_r[0] <= mem_dq_in;
        for (int i = 1; i < PW; i++)
            dly_data_r[i] <= dly_data_r[i-1];
    end

    assign ret_hit      = rd_pipe_r[sq.latency];
    assign sq.rd_ret    = ret_hit;
    assign sq.rd_match  = ret_hit & (&dly_data_r[sq.latency]);

    always_ff @(posedge clk or negedge phy_rst_b)
    begin
        if (!phy_rst_b)
        begin
            ctrl_rdata       <= '0;
            ctrl_rdata_valid <= '0;
            cal_success      <= 1'b0;
            cal_fail         <= 1'b0;
        end
        else
        begin
            ctrl_rdata       <= dly_data_r[sq.latency];
            ctrl_rdata_valid <= (ret_hit & ~sq.owns_bus) ? '1 : '0;
            cal_success      <= sq.passed;
            cal_fail         <= sq.failed & ~sq.passed;
        end
    end

    // command and write forwarding, sequencer drives its own calibration reads on the bus until handover
    always_ff @(posedge clk or negedge phy_rst_b)
    begin
        if (!phy_rst_b)
        begin
            mem_addr         <= '0;
            mem_bank         <= '0;
            mem_cs_b         <= '1;
            mem_ras_b        <= '1;
            mem_cas_b        <= '1;
            mem_we_b         <= '1;
            mem_dq_out       <= '0;
            mem_dq_oe_b      <= '1;
            memory_mask_pins <= '0;
            memory_mask_oe_b <= '1;
        end
        else if (sq.owns_bus)
        begin
            mem_cs_b    <= sq.rd_req ? '0 : '1;
            mem_we_b    <= '1;
            mem_dq_out  <= '1;
            mem_dq_oe_b <= '1;
        end
        else
        begin
            mem_addr         <= ctrl_addr;
            mem_bank         <= ctrl_bank;
            mem_cs_b         <= ctrl_cs_b;
            mem_ras_b        <= ctrl_ras_b;
            mem_cas_b        <= ctrl_cas_b;
            mem_we_b         <= ctrl_we_b;
            mem_dq_out       <= ctrl_wdata;
            memory_mask_pins <= ctrl_write_mask;
            for (int p = 0; p < `RATE_RATIO; p++)
            begin
                mem_dq_oe_b[p*DQ_PH +: DQ_PH] <= {DQ_PH{~ctrl_wdata_valid[p]}};
                memory_mask_oe_b[p]           <= ~ctrl_wdata_valid[p];
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/phy_consts.svh
// constants for the controller-facing side of the memory phy
// assumes inclusion by bare name from the phy package and modules
// Functional notes
// - add-margin step raises read latency counter by three cycles
// - after margin, below minimum latency fails calibration, else it passes
// - matching read lowers latency by one and retries; mismatch goes to margin; code goes to margin on a match once latency is zero
// - latency calibration starts with counter at predefined maximum
// - sharing master builds its own clock generator and delay line, drives ports
// - sharing slave takes clocks and delay codeword from input ports
// - clock and codeword signals are outputs on master, inputs on slave
// - termination master contains control unit and outputs both termination buses
// - global reset low resets clock generator and all phy logic; code leaves the read delay pipe dly_data_r without reset
// - soft reset low holds phy and interface reset low, clock generator runs
// - reset request high while clock generator locked, low out of lock
// - interface reset asserts asynchronously, releases synchronously to interface clock
// - four-stage release pipeline, held in reset until clock generator locks
// - rate ratio is one full rate, two half rate; fields replicated by it
// - interface clock goes out; all controller signals synchronous to it
// - write data twice memory width times ratio plus mask become memory outputs
// - data and mask output enables come from write-data-valid
// - read-data-valid per phase marks data on the read bus; code raises all phases together
// - success output goes high on pass, fail output high on failure
`ifndef PHY_CONSTS_SVH
`define PHY_CONSTS_SVH
`define RATE_RATIO      2
`define MEM_ADDR_W      19
`define MEM_BANK_W      3
`define MEM_CS_W        1
`define MEM_CTL_W       1
`define MEM_DQ_W        9
`define MEMORY_MASK_PINS_W        1
`define MEM_WDQS_W      1
`define MEM_RDQS_W      1
`define DLY_CODE_W      7
`define TERM_SER_W      16
`define TERM_PAR_W      16
`define LAT_W           6
`define LAT_MAX         6'h1f
`define LAT_MIN         6'h04
`define LAT_STEP        6'h01
`define LAT_MARGIN      6'h03
`define SYNC_STAGES     4
`define LOCK_CNT_W      4
`define LOCK_CNT_DONE   4'hf
`define DIV_CNT_W       2
`define DLY_CODE_INIT   7'h20
`define TERM_SER_INIT   16'h1234
`define TERM_PAR_INIT   16'h5678
`endif

// ===== rtl/phy_pkg.sv
// types shared by the phy modules
// assumes the constants header sits beside it
package phy_pkg;
`include "phy_consts.svh"
    typedef enum logic [3:0]
    {
        seq_idle,
        seq_write_pattern,
        seq_read_issue,
        seq_read_wait,
        seq_compare,
        seq_reduce,
        seq_flush,
        seq_add_margin,
        calibration_passed_state,
        calibration_failed_state
    } seq_state_e;
    typedef logic [`LAT_W-1:0] lat_t;
endpackage

// ===== rtl/seq_if.sv
// carrier between the sequencer and the phy top
// assumes one clock, the interface clock
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
interface seq_if;
    logic rd_req;
    logic rd_ret;
    logic rd_match;
    logic owns_bus;
    logic [`LAT_W-1:0] latency;
    logic passed;
    logic failed;
    modport seq
    (
        input  rd_ret, rd_match,
        output rd_req, owns_bus, latency, passed, failed
    );
    modport top
    (
        output rd_ret, rd_match,
        input  rd_req, owns_bus, latency, passed, failed
    );
endinterface
`default_nettype wire

// ===== rtl/reset_sync.sv
// four-stage reset release pipeline
// assumes asynchronous active-low request, release on clk
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module reset_sync
(
    input  wire logic clk,
    input  wire logic arst_b,
    output logic      srst_b
);
    logic [`SYNC_STAGES-1:0] pipe_r;
    always_ff @(posedge clk or negedge arst_b)
    begin
        if (!arst_b)
            pipe_r <= '0;
        else
            pipe_r <= {pipe_r[`SYNC_STAGES-2:0], 1'b1};
    end
    assign srst_b = pipe_r[`SYNC_STAGES-1];
endmodule
`default_nettype wire

// ===== rtl/lat_calib.sv
// read latency calibration sequencer
// assumes the top returns read results through the carrier
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module lat_calib
(
    input  wire logic clk,
    input  wire logic rst_b,
    seq_if.seq        sq
);
    import phy_pkg::*;
    seq_state_e state_r;
    lat_t       lat_r;
    logic       match_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= seq_idle;
            lat_r   <= `LAT_MAX;
            match_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                seq_idle:          state_r <= seq_write_pattern;
                seq_write_pattern: state_r <= seq_read_issue;
                seq_read_issue:    state_r <= seq_read_wait;
                seq_read_wait:
                    if (sq.rd_ret)
                    begin
                        state_r <= seq_compare;
                        // latch now: the return pipe has moved on by compare
                        match_r <= sq.rd_match;
                    end
                seq_compare:
                    state_r <= match_r ? seq_reduce : seq_add_margin;
                // floor at zero so the reduce step cannot wrap the counter below zero
                seq_reduce:
                    if (lat_r == '0)
                        state_r <= seq_add_margin;
                    else
                    begin
                        lat_r   <= lat_r - `LAT_STEP;
                        state_r <= seq_flush;
                    end
                seq_flush:         state_r <= seq_read_issue;
                seq_add_margin:
                begin
                    lat_r <= lat_r + `LAT_MARGIN;
                    if ((lat_r + `LAT_MARGIN) < `LAT_MIN)
                        state_r <= calibration_failed_state;
                    else
                        state_r <= calibration_passed_state;
                end
                calibration_passed_state: state_r <= calibration_passed_state;
                calibration_failed_state: state_r <= calibration_failed_state;
                default:           state_r <= seq_idle;
            endcase
        end
    end
    assign sq.rd_req   = (state_r == seq_read_issue) || (state_r == seq_flush);
    assign sq.owns_bus = (state_r != calibration_passed_state);
    assign sq.latency  = lat_r;
    assign sq.passed   = (state_r == calibration_passed_state);
    assign sq.failed   = (state_r == calibration_failed_state);
endmodule
`default_nettype wire

// ===== tb/mem_phy_asserts.sv
// checker bound to the phy top, watching reset, calibration status and forwarding
// assumes the constants header is on the include path
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module mem_phy_asserts
(
    input wire logic                                clk,
    input wire logic                                rst_b,
    input wire logic                                soft_rst_b,
    input wire logic                                reset_req_b,
    input wire logic                                if_clk_en,
    input wire logic                                if_rst_b,
    input wire logic [`MEM_ADDR_W*`RATE_RATIO-1:0]  ctrl_addr,
    input wire logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]  ctrl_wdata,
    input wire logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]    ctrl_write_mask,
    input wire logic [`MEM_WDQS_W*`RATE_RATIO-1:0]  ctrl_wdata_valid,
    input wire logic                                cal_success,
    input wire logic                                cal_fail,
    input wire logic [`MEM_ADDR_W*`RATE_RATIO-1:0]  mem_addr,
    input wire logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]  mem_dq_out,
    input wire logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]  mem_dq_oe_b,
    input wire logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]    memory_mask_pins,
    input wire logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]    memory_mask_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !soft_rst_b);
    // two cycles of success so the sampled command is surely the controller's
    cal_exclusive_a: assert property (!(cal_success && cal_fail)) else $error("success and fail both high");
    cal_sticky_a: assert property (cal_success |=> cal_success) else $error("success dropped");
    fail_sticky_a: assert property (cal_fail |=> cal_fail) else $error("fail dropped");
    soft_hold_a: assert property (@(posedge clk) disable iff (!rst_b) !soft_rst_b |-> !if_rst_b)
        else $error("interface reset released under soft reset");
    sync_depth_a: assert property ($rose(if_rst_b) |-> $past(soft_rst_b, 1) && $past(soft_rst_b, 4))
        else $error("interface reset released too early");
    lock_gate_a: assert property (@(posedge clk) disable iff (!rst_b) !reset_req_b |-> !if_rst_b)
        else $error("interface reset released without lock");
    rate_toggle_a: assert property ($past(rst_b) |-> if_clk_en != $past(if_clk_en))
        else $error("interface enable not every second cycle");
    cmd_forward_a: assert property (cal_success && $past(cal_success, 2) |-> mem_addr == $past(ctrl_addr))
        else $error("address not forwarded");
    data_forward_a: assert property (cal_success && $past(cal_success, 2)
        |-> mem_dq_out == $past(ctrl_wdata) && memory_mask_pins == $past(ctrl_write_mask))
        else $error("write data or mask not forwarded");
    enable_map_a: assert property (cal_success && $past(cal_success, 2)
        |-> mem_dq_oe_b == {{(`MEM_DQ_W*2){!$past(ctrl_wdata_valid[1])}}, {(`MEM_DQ_W*2){!$past(ctrl_wdata_valid[0])}}}
        && memory_mask_oe_b == ~$past(ctrl_wdata_valid))
        else $error("output enables not from write valid");
endmodule
bind mem_phy mem_phy_asserts u_mem_phy_asserts
(
    .clk(clk), .rst_b(rst_b), .soft_rst_b(soft_rst_b), .reset_req_b(reset_req_b), .if_clk_en(if_clk_en),
    .if_rst_b(if_rst_b), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_write_mask(ctrl_write_mask),
    .ctrl_wdata_valid(ctrl_wdata_valid), .cal_success(cal_success), .cal_fail(cal_fail), .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_b(mem_dq_oe_b), .memory_mask_pins(memory_mask_pins),
    .memory_mask_oe_b(memory_mask_oe_b)
);
`default_nettype wire

// ===== tb/ctrl_model.sv
// memory controller model driving the controller side of the phy
// assumes commands are only issued once calibration has passed
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module ctrl_model
(
    input  wire logic                                clk,
    input  wire logic                                cal_success,
    output logic [`MEM_ADDR_W*`RATE_RATIO-1:0]       ctrl_addr,
    output logic [`MEM_BANK_W*`RATE_RATIO-1:0]       ctrl_bank,
    output logic [`MEM_CS_W*`RATE_RATIO-1:0]         ctrl_cs_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_ras_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_cas_b,
    output logic [`MEM_CTL_W*`RATE_RATIO-1:0]        ctrl_we_b,
    output logic [`MEM_DQ_W*2*`RATE_RATIO-1:0]       ctrl_wdata,
    output logic [`MEMORY_MASK_PINS_W*`RATE_RATIO-1:0]         ctrl_write_mask,
    output logic [`MEM_WDQS_W*`RATE_RATIO-1:0]       ctrl_wdata_valid,
    output logic [`MEM_RDQS_W*`RATE_RATIO-1:0]       ctrl_rdata_en
);
    initial
    begin
        {ctrl_addr, ctrl_bank, ctrl_wdata, ctrl_write_mask, ctrl_wdata_valid, ctrl_rdata_en} = '0;
        {ctrl_cs_b, ctrl_ras_b, ctrl_cas_b, ctrl_we_b} = '1;
    end
    // one command per phase pair; writes where valid, reads on the other phases
    task automatic issue(input logic [`MEM_ADDR_W*`RATE_RATIO-1:0] a, input logic [`MEM_DQ_W*2*`RATE_RATIO-1:0] d,
                         input logic [1:0] v, input logic [1:0] m);
        @(posedge clk);
        #1;
        if (cal_success !== 1'b1)
            return;
        ctrl_addr        = a;
        ctrl_bank        = a[5:0];
        ctrl_cs_b        = 2'h0;
        ctrl_ras_b       = ~a[1:0];
        ctrl_cas_b       = a[3:2];
        ctrl_we_b        = ~v;
        ctrl_wdata       = d;
        ctrl_write_mask  = m;
        ctrl_wdata_valid = v;
        ctrl_rdata_en    = ~v;
    endtask
endmodule
`default_nettype wire

// ===== tb/mem_phy_calib_and_ctrl_iface_test.sv
// self-checking bench for the phy top as sharing and termination master
// assumes the phy package, carrier, checker and controller model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "phy_consts.svh"
module mem_phy_calib_and_ctrl_iface_test;
    typedef struct packed
    {
        logic [37:0] a;
        logic [35:0] d;
        logic [1:0]  v;
        logic [1:0]  m;
    } row_s;
    localparam row_s ROWS [4] = '{'{38'h0000000001, 36'h000000000, 2'h0, 2'h0},
                                  '{38'h3fffffffff, 36'hfffffffff, 2'h3, 2'h3},
                                  '{38'h2aaaaaaaaa, 36'h555555555, 2'h1, 2'h2},
                                  '{38'h1555555555, 36'haaaaaaaaa, 2'h2, 2'h1}};
    logic clk = 1'b0, rst_b = 1'b0, soft_rst_b = 1'b1;
    logic reset_req_b, if_clk_en, if_rst_b, share_clk_out, cal_success, cal_fail, clk_seen;
    logic [6:0]  dly_code_out;
    logic [15:0] term_ser_out, term_par_out;
    logic [37:0] ctrl_addr, mem_addr;
    logic [5:0]  ctrl_bank, mem_bank;
    logic [1:0]  ctrl_cs_b, ctrl_ras_b, ctrl_cas_b, ctrl_we_b, mem_cs_b, mem_ras_b, mem_cas_b, mem_we_b;
    logic [1:0]  ctrl_write_mask, ctrl_wdata_valid, ctrl_rdata_en, ctrl_rdata_valid, mask_pins, mask_oe_b;
    logic [35:0] ctrl_wdata, ctrl_rdata, mem_dq_out, mem_dq_oe_b;
    logic [35:0] mem_dq_in = 36'h000000000;
    int failures = 0;
    int compares = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    // slave-side inputs fed from master outputs, as an integrator wires a slave
    mem_phy u_mem_phy (.clk(clk), .rst_b(rst_b), .soft_rst_b(soft_rst_b), .lock_in(reset_req_b),
        .share_clk_in(share_clk_out), .dly_code_in(dly_code_out), .share_clk_out(share_clk_out),
        .dly_code_out(dly_code_out), .term_ser_in(term_ser_out), .term_par_in(term_par_out),
        .term_ser_out(term_ser_out), .term_par_out(term_par_out), .reset_req_b(reset_req_b),
        .if_clk_en(if_clk_en), .if_rst_b(if_rst_b), .ctrl_addr(ctrl_addr), .ctrl_bank(ctrl_bank),
        .ctrl_cs_b(ctrl_cs_b), .ctrl_ras_b(ctrl_ras_b), .ctrl_cas_b(ctrl_cas_b), .ctrl_we_b(ctrl_we_b),
        .ctrl_wdata(ctrl_wdata), .ctrl_write_mask(ctrl_write_mask), .ctrl_wdata_valid(ctrl_wdata_valid),
        .ctrl_rdata_en(ctrl_rdata_en), .ctrl_rdata(ctrl_rdata), .ctrl_rdata_valid(ctrl_rdata_valid),
        .cal_success(cal_success), .cal_fail(cal_fail), .mem_addr(mem_addr), .mem_bank(mem_bank),
        .mem_cs_b(mem_cs_b), .mem_ras_b(mem_ras_b), .mem_cas_b(mem_cas_b), .mem_we_b(mem_we_b),
        .mem_dq_out(mem_dq_out), .mem_dq_oe_b(mem_dq_oe_b), .mem_dq_in(mem_dq_in),
        .memory_mask_pins(mask_pins), .memory_mask_oe_b(mask_oe_b));
    ctrl_model u_ctrl_model (.clk(clk), .cal_success(cal_success), .ctrl_addr(ctrl_addr), .ctrl_bank(ctrl_bank),
        .ctrl_cs_b(ctrl_cs_b), .ctrl_ras_b(ctrl_ras_b), .ctrl_cas_b(ctrl_cas_b), .ctrl_we_b(ctrl_we_b),
        .ctrl_wdata(ctrl_wdata), .ctrl_write_mask(ctrl_write_mask), .ctrl_wdata_valid(ctrl_wdata_valid),
        .ctrl_rdata_en(ctrl_rdata_en));
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    // bounded wait for a status output to go high
    task automatic wait_hi(input int sel, input int limit);
        int n;
        n = 0;
        while (n < limit && !((sel == 0 && reset_req_b === 1'b1) || (sel == 1 && if_rst_b === 1'b1)
                              || (sel == 2 && cal_success === 1'b1) || (sel == 3 && cal_fail === 1'b1)))
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= limit)
        begin
            failures++;
            $display("Error at %0t: wait %0d timed out", $time, sel);
            complete_run();
        end
    endtask
    task automatic bring_up();
        wait_hi(0, 100);
        wait_hi(1, 100);
        wait_hi(2, 4000);
        // first read mismatches, latency ends above the minimum
        chk(cal_fail, 1'b0, "cal fail");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk(reset_req_b, 1'b0, "lock before count");
        chk(if_rst_b, 1'b0, "if reset at start");
        bring_up();
        chk(dly_code_out, `DLY_CODE_INIT, "delay code");
        chk(term_ser_out, `TERM_SER_INIT, "series term");
        chk(term_par_out, `TERM_PAR_INIT, "parallel term");
        clk_seen = share_clk_out;
        repeat (2) @(posedge clk);
        #1;
        chk(share_clk_out, !clk_seen, "shared clock");
        foreach (ROWS[i])
        begin
            u_ctrl_model.issue(ROWS[i].a, ROWS[i].d, ROWS[i].v, ROWS[i].m);
            @(posedge clk);
            #1;
            chk(mem_addr, ROWS[i].a, "addr");
            chk(mem_bank, ROWS[i].a[5:0], "bank");
            chk(mem_we_b, 2'(~ROWS[i].v), "write enable");
            chk(mem_cs_b, 2'h0, "select");
            chk(mem_ras_b, 2'(~ROWS[i].a[1:0]), "row strobe");
            chk(mem_cas_b, ROWS[i].a[3:2], "column strobe");
            chk(mem_dq_out, ROWS[i].d, "write data");
            chk(mask_pins, ROWS[i].m, "mask");
            chk(mem_dq_oe_b, {{18{~ROWS[i].v[1]}}, {18{~ROWS[i].v[0]}}}, "dq enable");
            chk(mask_oe_b, 2'(~ROWS[i].v), "mask enable");
        end
        // last row keeps a read enable up, so returns arrive every cycle
        repeat (40) @(posedge clk);
        #1;
        chk(ctrl_rdata_valid, 2'h3, "read valid");
        soft_rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(if_rst_b, 1'b0, "if reset in soft");
        chk(cal_success, 1'b0, "success in soft");
        chk(reset_req_b, 1'b1, "lock kept in soft");
        soft_rst_b = 1'b1;
        wait_hi(1, 100);
        wait_hi(2, 4000);
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        #1;
        chk(if_rst_b, 1'b0, "async assert");
        chk(reset_req_b, 1'b0, "lock lost");
        chk(cal_success, 1'b0, "success cleared");
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        bring_up();
        // all-ones data matches at every latency, so the counter bottoms out and fails
        mem_dq_in = '1;
        soft_rst_b = 1'b0;
        @(posedge clk);
        #1;
        soft_rst_b = 1'b1;
        wait_hi(3, 4000);
        chk(cal_success, 1'b0, "success with fail");
        complete_run();
    end
endmodule
`default_nettype wire
